//--- core/gate_bank_params.svh
// offsets, field positions, reset values and key constants of the gating bank
`ifndef GATE_BANK_PARAMS_SVH
`define GATE_BANK_PARAMS_SVH

// ==========================================================
// register base addresses (alias offsets added on top of the gating ones)
`define GB_OFS_CONTROL   12'h000
`define GB_OFS_ANALOG    12'h010
`define GB_OFS_COMPARE   12'h020
`define GB_OFS_CAPTURE   12'h030
`define GB_OFS_TIMER     12'h040
`define GB_OFS_SERIAL    12'h050
`define GB_OFS_CALENDAR  12'h060
`define GB_OFS_CHECKSUM  12'h070
`define GB_OFS_KEY       12'h100
`define GB_OFS_CFGCTL    12'h110
`define GB_OFS_DEVICE_IDENTIFICATION_REGISTER     12'h120
`define GB_OFS_PWRCFG    12'h130

// ==========================================================
// alias offsets
`define GB_ALIAS_CLR     4'h4
`define GB_ALIAS_SET     4'h8
`define GB_ALIAS_INV     4'hc

// ==========================================================
// implemented bit masks per gating register, index 0 = control
`define GB_MASK_CONTROL  32'h0000_0800
`define GB_MASK_ANALOG   32'h0010_1001
`define GB_MASK_COMPARE  32'h0300_0003
`define GB_MASK_CAPTURE  32'h0000_0700
`define GB_MASK_TIMER    32'h0000_0001
`define GB_MASK_SERIAL   32'h0000_0303
`define GB_MASK_CALENDAR 32'h0000_0101
`define GB_MASK_CHECKSUM 32'h0000_0008

// ==========================================================
// field positions and reset values
`define GB_LOCK_BIT      11
`define GB_LPBOR_BIT     3
`define GB_EXEC_MSB      7
`define GB_EXEC_STEP     1024
`define GB_KEY_FIRST     32'haa99_6655
`define GB_KEY_SECOND    32'h5566_99aa
`define GB_RESET_CONTROL 32'h0000_0800
`define GB_DEVICE_IDENTIFICATION_REGISTER_VALUE   32'h0123_4567

`endif

//--- core/gate_bank_pkg.sv
// types of the gating bank
package gate_bank_pkg;
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b11
    } key_state_e;
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_CLR   = 2'b01,
        OP_SET   = 2'b10,
        OP_INV   = 2'b11
    } alias_op_t;
endpackage

//--- core/gate_bank_if.sv
// carrier between the bus slave and the key sequencer
`timescale 1ns/1ps
interface gate_key_if;
    logic        wr_stb;
    logic [31:0] wr_data;
    logic        unlocked;
    modport bank (output wr_stb, output wr_data, input unlocked);
    modport seq  (input wr_stb, input wr_data, output unlocked);
endinterface

//--- core/system_key_seq.sv
// unlock key sequencer
`timescale 1ns/1ps
`include "gate_bank_params.svh"
module system_key_seq (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    gate_key_if.seq     key
);
    gate_bank_pkg::key_state_e state_reg;
    gate_bank_pkg::key_state_e state_next;
    wire is_first  = key.wr_data == `GB_KEY_FIRST;
    wire is_second = key.wr_data == `GB_KEY_SECOND;

    // ==========================================================
    // key sequence: first key then second key opens, a repeated first key keeps the first step, any other value relocks
    always_comb begin
        state_next = state_reg;
        if (key.wr_stb) begin
            case (state_reg)
                gate_bank_pkg::KEY_LOCKED: begin
                    state_next = is_first ? gate_bank_pkg::KEY_HALF
                                          : gate_bank_pkg::KEY_LOCKED;
                end
                gate_bank_pkg::KEY_HALF: begin
                    state_next = is_second ? gate_bank_pkg::KEY_OPEN
                               : is_first ? gate_bank_pkg::KEY_HALF
                                          : gate_bank_pkg::KEY_LOCKED;
                end
                default: begin
                    state_next = is_first ? gate_bank_pkg::KEY_HALF
                                          : gate_bank_pkg::KEY_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= gate_bank_pkg::KEY_LOCKED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign key.unlocked = state_reg == gate_bank_pkg::KEY_OPEN;
endmodule

//--- core/module_gate_config_bank.sv
// apb register bank for module gating and system configuration
`timescale 1ns/1ps
`include "gate_bank_params.svh"
module module_gate_config_bank #(
    parameter logic [31:0] DEVICE_ID = `GB_DEVICE_IDENTIFICATION_REGISTER_VALUE  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] module_gate_bit,
    output logic      [31:0] module_clk_enable,
    output logic      [7:0]  ram_exec_boundary,
    output logic      [15:0] ram_exec_base_kb,
    output logic             low_power_brownout_enable,
    output logic             gate_write_lock
);
    localparam int NREG = 8;
    localparam logic [31:0] MASKS [NREG] = '{`GB_MASK_CONTROL, `GB_MASK_ANALOG,
        `GB_MASK_COMPARE, `GB_MASK_CAPTURE, `GB_MASK_TIMER, `GB_MASK_SERIAL,
        `GB_MASK_CALENDAR, `GB_MASK_CHECKSUM};

    gate_key_if key ();

    logic [31:0] gate_reg [NREG];
    logic [31:0] gate_next [NREG];
    logic [7:0]  exec_reg;
    logic        lpbor_reg;
    logic        unlock_seen_reg;

    // ==========================================================
    // access decode
    wire        acc     = psel && penable;
    wire        wr      = acc && pwrite;
    wire [2:0]  gidx    = paddr[6:4];
    wire        in_gate = paddr[11:7] == 5'h00 && paddr[1:0] == 2'b00;
    wire [1:0]  op      = paddr[3:2];
    wire        is_key  = paddr == `GB_OFS_KEY;
    wire        is_cfg  = paddr == `GB_OFS_CFGCTL;
    wire        is_id   = paddr == `GB_OFS_DEVICE_IDENTIFICATION_REGISTER;
    wire        is_pwr  = paddr == `GB_OFS_PWRCFG;
    wire        mapped  = in_gate || is_key || is_cfg || is_id || is_pwr;
    wire [31:0] bmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire        lock    = gate_reg[0][`GB_LOCK_BIT];

    // ==========================================================
    // alias arithmetic
    function automatic logic [31:0] apply_op(input logic [1:0] o, input logic [31:0] cur,
                                             input logic [31:0] d, input logic [31:0] m);
        logic [31:0] w;
        w = d & m;
        case (o)
            2'(gate_bank_pkg::OP_CLR): apply_op = cur & ~w;
            2'(gate_bank_pkg::OP_SET): apply_op = cur | w;
            2'(gate_bank_pkg::OP_INV): apply_op = cur ^ w;
            default:                   apply_op = (cur & ~m) | w;
        endcase
    endfunction

    assign key.wr_stb  = wr && is_key;
    assign key.wr_data = pwdata;

    system_key_seq u_key (
        .clk     (clk),
        .sys_rst (sys_rst),
        .key     (key)
    );

    // ==========================================================
    // gating registers with aliases
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : gen_gate
            wire hit   = wr && in_gate && gidx == 3'(g);
            wire allow = (g == 0) ? key.unlocked : !lock;
            assign gate_next[g] = (hit && allow)
                ? apply_op(op, gate_reg[g], pwdata & bmask, MASKS[g]) & MASKS[g]
                : gate_reg[g];
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    gate_reg[g] <= (g == 0) ? `GB_RESET_CONTROL : 32'h0000_0000;
                end else begin
                    gate_reg[g] <= gate_next[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // read data; unimplemented gating bits read as one
    wire [31:0] gate_rd = gate_reg[gidx] | ~MASKS[gidx];
    wire [31:0] rd_mux =
        in_gate ? gate_rd :
        is_key  ? {31'h0, key.unlocked} :
        is_cfg  ? {24'h0, exec_reg} :
        is_id   ? DEVICE_ID :
        is_pwr  ? {28'h0, lpbor_reg, 3'h0} : 32'h0000_0000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            exec_reg  <= 8'h00;
            lpbor_reg <= 1'b0;
        end else if (wr) begin
            if (is_cfg && pstrb[0]) begin
                exec_reg <= pwdata[`GB_EXEC_MSB:0];
            end
            if (is_pwr && pstrb[0]) begin
                lpbor_reg <= pwdata[`GB_LPBOR_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unlock_seen_reg <= 1'b0;
        end else begin
            unlock_seen_reg <= key.unlocked;
        end
    end

    // ==========================================================
    // apb answer: zero wait states, error on unmapped address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================================
    // registered outputs
    logic [31:0] gate_flat;
    always_comb begin
        gate_flat = 32'h0000_0000;
        for (int i = 1; i < NREG; i++) begin
            gate_flat[i*4 +: 4] = |gate_reg[i] ? 4'hf : 4'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            module_gate_bit           <= 32'h0000_0000;
            module_clk_enable         <= 32'hffff_ffff;
            ram_exec_boundary         <= 8'h00;
            ram_exec_base_kb          <= 16'h0000;
            low_power_brownout_enable <= 1'b0;
            gate_write_lock           <= 1'b1;
        end else begin
            module_gate_bit           <= gate_flat;
            module_clk_enable         <= ~gate_flat;
            ram_exec_boundary         <= exec_reg;
            ram_exec_base_kb          <= {8'h00, exec_reg};
            low_power_brownout_enable <= lpbor_reg;
            gate_write_lock           <= lock;
        end
    end
endmodule

//--- verif/gate_bank_checker_props.sv
// concurrent checks on the gating bank ports
`timescale 1ns/1ps
`include "gate_bank_params.svh"
module gate_bank_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] module_gate_bit,
    input wire logic [31:0] module_clk_enable,
    input wire logic [7:0]  ram_exec_boundary,
    input wire logic [15:0] ram_exec_base_kb,
    input wire logic        low_power_brownout_enable,
    input wire logic        gate_write_lock
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // completed write access
    wire logic wr_acc = psel && penable && pwrite && pready;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_one_cycle: assert property (s_setup |=> s_access)
        else $error("ready late");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("stray ready");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray error");
    a_clk_enable_inv: assert property (module_clk_enable == ~module_gate_bit)
        else $error("clock enable mismatch");
    a_base_kb_step: assert property (ram_exec_base_kb == {8'h00, ram_exec_boundary})
        else $error("base mismatch");
    a_boundary_source: assert property ($changed(ram_exec_boundary) |->
        $past(wr_acc && paddr == `GB_OFS_CFGCTL, 2)) else $error("boundary moved");
    a_lpbor_source: assert property ($changed(low_power_brownout_enable) |->
        $past(wr_acc && paddr == `GB_OFS_PWRCFG, 2)) else $error("lpbor moved");
    a_lock_source: assert property ($changed(gate_write_lock) |->
        $past(wr_acc && paddr == `GB_OFS_CONTROL, 2)) else $error("lock moved");
    a_locked_stable: assert property (gate_write_lock && $past(gate_write_lock) &&
        $past(gate_write_lock, 2) |-> $stable(module_gate_bit)) else $error("gates moved");
endmodule
bind module_gate_config_bank gate_bank_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .module_gate_bit(module_gate_bit),
    .module_clk_enable(module_clk_enable), .ram_exec_boundary(ram_exec_boundary),
    .ram_exec_base_kb(ram_exec_base_kb), .gate_write_lock(gate_write_lock),
    .low_power_brownout_enable(low_power_brownout_enable));

//--- verif/module_gate_config_bank_bench.sv
// self-checking bench for the gating bank
`timescale 1ns/1ps
`include "gate_bank_params.svh"
module module_gate_config_bank_bench;
    localparam logic [31:0] ID_VAL = 32'h5a5a_0001;  // arbitrary value
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
    logic        low_power_brownout_enable, gate_write_lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, module_gate_bit, module_clk_enable, rd;
    logic [3:0]  pstrb;
    logic [7:0]  ram_exec_boundary;
    logic [15:0] ram_exec_base_kb;
    logic [31:0] masks [1:7];
    int          err_count, compares;
    module_gate_config_bank #(.DEVICE_ID(ID_VAL)) u_dut (.clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .module_gate_bit,
        .module_clk_enable, .ram_exec_boundary, .ram_exec_base_kb,
        .low_power_brownout_enable, .gate_write_lock);
    // ==========================================================
    // bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            err_count++;
            $display("Error pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    // registered outputs lag the write edge by one cycle
    task automatic settle;
        @(posedge clk);
    endtask
    task automatic end_of_test;
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_locked;
        apb(1'b1, `GB_OFS_ANALOG, 32'hffff_ffff);
        apb(1'b0, `GB_OFS_ANALOG, 32'h0);
        chk("analog", ~`GB_MASK_ANALOG, rd);
        chk("lock", 32'h1, {31'h0, gate_write_lock});
        chk("clk_en", 32'hffff_ffff, module_clk_enable);
    endtask
    task automatic t_unlock;
        apb(1'b1, `GB_OFS_KEY, `GB_KEY_FIRST);
        apb(1'b1, `GB_OFS_KEY, `GB_KEY_SECOND);
        apb(1'b0, `GB_OFS_KEY, 32'h0);
        chk("key", 32'h1, {31'h0, rd[0]});
        apb(1'b1, `GB_OFS_CONTROL, 32'h0);
        settle();
        chk("lock", 32'h0, {31'h0, gate_write_lock});
        apb(1'b1, `GB_OFS_KEY, 32'h0);
        apb(1'b1, `GB_OFS_CONTROL, 32'h800);
        settle();
        chk("relock", 32'h0, {31'h0, gate_write_lock});
        apb(1'b1, `GB_OFS_KEY, `GB_KEY_FIRST);
        apb(1'b1, `GB_OFS_KEY, 32'h1);
        apb(1'b1, `GB_OFS_KEY, `GB_KEY_SECOND);
        apb(1'b0, `GB_OFS_KEY, 32'h0);
        chk("bad_key", 32'h0, {31'h0, rd[0]});
    endtask
    task automatic t_alias;
        logic [11:0] b;
        for (int i = 1; i < 8; i++) begin
            b = 12'(16 * i);
            apb(1'b1, b + `GB_ALIAS_SET, masks[i]);
            apb(1'b0, b, 32'h0);
            chk("set", 32'hffff_ffff, rd);
            chk("gate", 32'hf, 32'(module_gate_bit[4*i +: 4]));
            apb(1'b1, b + `GB_ALIAS_INV, masks[i]);
            apb(1'b0, b, 32'h0);
            chk("inv", ~masks[i], rd);
            apb(1'b1, b, 32'hffff_ffff);
            apb(1'b1, b + `GB_ALIAS_CLR, masks[i]);
            apb(1'b0, b, 32'h0);
            chk("clr", ~masks[i], rd);
            chk("gate0", 32'h0, 32'(module_gate_bit[4*i +: 4]));
        end
    endtask
    task automatic t_config;
        apb(1'b1, `GB_OFS_CFGCTL, 32'h0000_00ff);
        settle();
        chk("boundary", 32'hff, {24'h0, ram_exec_boundary});
        chk("base_kb", 32'hff, {16'h0, ram_exec_base_kb});
        apb(1'b1, `GB_OFS_PWRCFG, 32'h0000_0008);
        settle();
        chk("lpbor", 32'h1, {31'h0, low_power_brownout_enable});
        apb(1'b1, `GB_OFS_PWRCFG, 32'hffff_fff7);
        settle();
        chk("lpbor", 32'h0, {31'h0, low_power_brownout_enable});
        apb(1'b1, `GB_OFS_DEVICE_IDENTIFICATION_REGISTER, 32'h0);
        apb(1'b0, `GB_OFS_DEVICE_IDENTIFICATION_REGISTER, 32'h0);
        chk("device_identification_register", ID_VAL, rd);
        apb(1'b0, 12'h200, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("unmapped", 32'h0, rd);
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        masks = '{`GB_MASK_ANALOG, `GB_MASK_COMPARE, `GB_MASK_CAPTURE, `GB_MASK_TIMER,
                  `GB_MASK_SERIAL, `GB_MASK_CALENDAR, `GB_MASK_CHECKSUM};
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        pstrb = 4'hf;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_locked();
        t_unlock();
        t_alias();
        t_config();
        end_of_test();
    end
endmodule
